/* File: core/arr_result_regs.sv */
// measurement result registers read over the serial register port
//
// What this block does
// - battery-voltage high byte at 0x1e: sign in bit 7, result bits 14..8.
// - battery-voltage low byte at 0x1f carries result bits 7..0.
// - output-voltage low byte at 0x1d carries result bits 7..0.
// - battery-current high byte at 0x20: sign in bit 7, bits 14..8.
// - battery-current low byte at 0x21 carries current bits 7..0.
// - bit 7 of each high byte is the two's-complement sign, 1 = negative.
// - battery current reads positive when charging, negative discharging.
// - the software register-reset command clears every result bit.
`default_nettype none

module arr_result_regs (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe_n,
  input  wire logic        result_load,
  input  wire logic [7:0]  output_voltage_result,
  input  wire logic [15:0] battery_voltage_result,
  input  wire logic [15:0] battery_current_result,
  input  wire logic        reg_reset_cmd
);

  // ----------------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------------
  logic [7:0]  vout_reg;
  logic [7:0]  vout_next;
  logic [15:0] vbat_reg;
  logic [15:0] vbat_next;
  logic [15:0] ibat_reg;
  logic [15:0] ibat_next;

  // the command wins over a same-cycle load so a reset is never undone
  always_comb begin
    vout_next = vout_reg;
    vbat_next = vbat_reg;
    ibat_next = ibat_reg;
    if (reg_reset_cmd) begin
      vout_next = arr_pkg::BYTE_RESET;
      vbat_next = arr_pkg::RESULT_RESET;
      ibat_next = arr_pkg::RESULT_RESET;
    end else if (result_load) begin
      vout_next = output_voltage_result;
      vbat_next = battery_voltage_result;
      ibat_next = battery_current_result;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vout_reg <= arr_pkg::BYTE_RESET;
      vbat_reg <= arr_pkg::RESULT_RESET;
      ibat_reg <= arr_pkg::RESULT_RESET;
    end else begin
      vout_reg <= vout_next;
      vbat_reg <= vbat_next;
      ibat_reg <= ibat_next;
    end
  end

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_byte(
    input logic [7:0]  addr,
    input logic [7:0]  vo,
    input logic [15:0] vb,
    input logic [15:0] ib
  );
    logic [7:0] data;
    data = arr_pkg::UNMAPPED_READ;
    case (addr)
      arr_pkg::ADDR_VOUT_LOW:  data = vo;
      arr_pkg::ADDR_VBAT_HIGH: data = vb[arr_pkg::HIGH_MSB:
                                         arr_pkg::HIGH_LSB];
      arr_pkg::ADDR_VBAT_LOW:  data = vb[arr_pkg::LOW_MSB:
                                         arr_pkg::LOW_LSB];
      arr_pkg::ADDR_IBAT_HIGH: data = ib[arr_pkg::HIGH_MSB:
                                         arr_pkg::HIGH_LSB];
      arr_pkg::ADDR_IBAT_LOW:  data = ib[arr_pkg::LOW_MSB:
                                         arr_pkg::LOW_LSB];
      default:                 data = arr_pkg::UNMAPPED_READ;
    endcase
    return data;
  endfunction

  // ----------------------------------------------------------------------
  // serial port front end
  // ----------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  arr_sync2 u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .pin_in   ({scl_in, sda_in}),
    .pin_sync (pins_sync)
  );

  wire scl_s     = pins_sync[1];
  wire sda_s     = pins_sync[0];
  wire scl_rise  = scl_s && !scl_prev_reg;
  wire scl_fall  = !scl_s && scl_prev_reg;
  wire start_cnd = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
  wire stop_cnd  = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

  // ----------------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------------
  arr_pkg::arr_state_t state_reg;
  arr_pkg::arr_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       drive_reg;
  logic       drive_next;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    cnt_next   = cnt_reg;
    drive_next = drive_reg;
    if (start_cnd) begin
      state_next = arr_pkg::ARR_ADDR;
      cnt_next   = arr_pkg::BIT_CNT_RESET;
      drive_next = 1'b0;
    end else if (stop_cnd) begin
      state_next = arr_pkg::ARR_IDLE;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        arr_pkg::ARR_IDLE: begin
          drive_next = 1'b0;
        end
        arr_pkg::ARR_ADDR, arr_pkg::ARR_REG, arr_pkg::ARR_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == arr_pkg::BIT_CNT_LAST) begin
              if (state_reg == arr_pkg::ARR_ADDR)
                // seven address bits are in, the direction bit is sda_s
                state_next = (shift_reg[6:0] == arr_pkg::TARGET_ADDR)
                             ? arr_pkg::ARR_ADDR_ACK : arr_pkg::ARR_IDLE;
              else if (state_reg == arr_pkg::ARR_REG)
                state_next = arr_pkg::ARR_REG_ACK;
              else
                state_next = arr_pkg::ARR_WDATA_ACK;
            end
          end
        end
        arr_pkg::ARR_ADDR_ACK, arr_pkg::ARR_REG_ACK,
        arr_pkg::ARR_WDATA_ACK: begin
          // drive_reg doubles as the phase: low before, high during ack
          if (scl_fall && !drive_reg) begin
            drive_next = 1'b1;
          end else if (scl_fall) begin
            drive_next = 1'b0;
            cnt_next   = arr_pkg::BIT_CNT_RESET;
            if (state_reg == arr_pkg::ARR_ADDR_ACK && shift_reg[0]) begin
              shift_next = read_byte(ptr_reg, vout_reg, vbat_reg, ibat_reg);
              drive_next = !shift_next[7];
              state_next = arr_pkg::ARR_RDATA;
            end else if (state_reg == arr_pkg::ARR_ADDR_ACK) begin
              state_next = arr_pkg::ARR_REG;
            end else if (state_reg == arr_pkg::ARR_REG_ACK) begin
              ptr_next   = shift_reg;
              state_next = arr_pkg::ARR_WDATA;
            end else begin
              // written byte is dropped; results stay as converted
              ptr_next   = ptr_reg + arr_pkg::POINTER_STEP;
              state_next = arr_pkg::ARR_WDATA;
            end
          end
        end
        arr_pkg::ARR_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == arr_pkg::BIT_CNT_LAST)
              state_next = arr_pkg::ARR_RDATA_ACK;
          end else if (scl_fall) begin
            shift_next = {shift_reg[6:0], 1'b0};
            drive_next = !shift_reg[6];
          end
        end
        arr_pkg::ARR_RDATA_ACK: begin
          if (scl_fall) begin
            drive_next = 1'b0;
          end else if (scl_rise && sda_s) begin
            state_next = arr_pkg::ARR_IDLE;
          end else if (scl_rise) begin
            ptr_next   = ptr_reg + arr_pkg::POINTER_STEP;
            state_next = arr_pkg::ARR_RLOAD;
          end
        end
        arr_pkg::ARR_RLOAD: begin
          if (scl_fall) begin
            shift_next = read_byte(ptr_reg, vout_reg, vbat_reg, ibat_reg);
            drive_next = !shift_next[7];
            cnt_next   = arr_pkg::BIT_CNT_RESET;
            state_next = arr_pkg::ARR_RDATA;
          end
        end
        default: begin
          state_next = arr_pkg::ARR_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg    <= arr_pkg::ARR_IDLE;
      shift_reg    <= arr_pkg::BYTE_RESET;
      ptr_reg      <= arr_pkg::POINTER_RESET;
      cnt_reg      <= arr_pkg::BIT_CNT_RESET;
      drive_reg    <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      ptr_reg      <= ptr_next;
      cnt_reg      <= cnt_next;
      drive_reg    <= drive_next;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // open drain: only ever pulls low, enable is active low
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drive_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  wire loading = result_load && !reg_reset_cmd;

  AST_VBAT_HIGH: assert property (
    loading |=> read_byte(arr_pkg::ADDR_VBAT_HIGH, vout_reg, vbat_reg,
      ibat_reg) == $past(battery_voltage_result[15:8]))
    else $error("battery voltage high byte wrong");
  AST_VBAT_LOW: assert property (
    loading |=> read_byte(arr_pkg::ADDR_VBAT_LOW, vout_reg, vbat_reg,
      ibat_reg) == $past(battery_voltage_result[7:0]))
    else $error("battery voltage low byte wrong");
  AST_VOUT_LOW: assert property (
    loading |=> read_byte(arr_pkg::ADDR_VOUT_LOW, vout_reg, vbat_reg,
      ibat_reg) == $past(output_voltage_result))
    else $error("output voltage low byte wrong");
  AST_IBAT_HIGH: assert property (
    loading |=> read_byte(arr_pkg::ADDR_IBAT_HIGH, vout_reg, vbat_reg,
      ibat_reg) == $past(battery_current_result[15:8]))
    else $error("battery current high byte wrong");
  AST_IBAT_LOW: assert property (
    loading |=> read_byte(arr_pkg::ADDR_IBAT_LOW, vout_reg, vbat_reg,
      ibat_reg) == $past(battery_current_result[7:0]))
    else $error("battery current low byte wrong");
  AST_VBAT_SIGN: assert property (
    loading ##1 !result_load && !reg_reset_cmd |-> vbat_reg[15] ==
      ($signed($past(battery_voltage_result)) < 0))
    else $error("battery voltage sign wrong");
  AST_IBAT_SIGN: assert property (
    loading && $signed(battery_current_result) > 0 |=> !ibat_reg[15])
    else $error("charging current reads negative");
  AST_REG_RESET: assert property (
    reg_reset_cmd |=> vout_reg == 8'h00 && vbat_reg == 16'h0000
      && ibat_reg == 16'h0000)
    else $error("register reset left result bits set");
  AST_WRITE_IGNORED: assert property (
    state_reg == arr_pkg::ARR_WDATA_ACK && !result_load && !reg_reset_cmd
      |=> $stable(vbat_reg) && $stable(ibat_reg) && $stable(vout_reg))
    else $error("host write changed a result");
  AST_WRITE_ACKED: assert property (
    state_reg == arr_pkg::ARR_WDATA_ACK && scl_fall && !drive_reg
      && !start_cnd && !stop_cnd |=> !sda_oe_n)
    else $error("write byte not acknowledged");

endmodule

`default_nettype wire

/* File: include/arr_pkg.sv */
// shared constants and types of the measurement result register bank
`default_nettype none

package arr_pkg;

  // ----------------------------------------------------------------------
  // register offsets on the serial register port
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_VOUT_LOW  = 8'h1d;
  localparam logic [7:0] ADDR_VBAT_HIGH = 8'h1e;
  localparam logic [7:0] ADDR_VBAT_LOW  = 8'h1f;
  localparam logic [7:0] ADDR_IBAT_HIGH = 8'h20;
  localparam logic [7:0] ADDR_IBAT_LOW  = 8'h21;

  // ----------------------------------------------------------------------
  // field layout: sign in bit 7 of a high byte, magnitude bits below
  // ----------------------------------------------------------------------
  localparam int SIGN_BIT   = 15;
  localparam int HIGH_MSB   = 15;
  localparam int HIGH_LSB   = 8;
  localparam int LOW_MSB    = 7;
  localparam int LOW_LSB    = 0;

  // ----------------------------------------------------------------------
  // values after reset and answers
  // ----------------------------------------------------------------------
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
  localparam logic [7:0]  POINTER_RESET = 8'h00;
  // arbitrary neutral target address, not tied to any part
  localparam logic [6:0]  TARGET_ADDR   = 7'h65;

  // ----------------------------------------------------------------------
  // serial port counts
  // ----------------------------------------------------------------------
  localparam logic [2:0]  BIT_CNT_RESET = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST  = 3'h7;
  localparam logic [7:0]  POINTER_STEP  = 8'h01;

  typedef enum logic [3:0] {
    ARR_IDLE,
    ARR_ADDR,
    ARR_ADDR_ACK,
    ARR_REG,
    ARR_REG_ACK,
    ARR_WDATA,
    ARR_WDATA_ACK,
    ARR_RDATA,
    ARR_RDATA_ACK,
    ARR_RLOAD
  } arr_state_t;

endpackage

`default_nettype wire

/* File: core/arr_sync2.sv */
// two-flop synchroniser for the serial clock and data pins
`default_nettype none

module arr_sync2 (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [1:0] pin_in,
  output var  logic [1:0] pin_sync
);

  logic [1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_reg <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* File: verif/arr_host_model.sv */
// serial host model that reads and writes the result registers
`default_nettype none

module arr_host_model (
  input  wire logic clock,
  input  wire logic dev_oe_n,
  input  wire logic dev_out,
  output var  logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic host_low;

  // ----------------------------------------------------------------------
  // open-drain data line with pull-up; scl idles high between frames
  // ----------------------------------------------------------------------
  assign sda = ~host_low & (dev_oe_n | dev_out);

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  // half period of 10 clocks, well above the 4-clock minimum
  task automatic hp();
    repeat (10) @(posedge clock);
    #5;
  endtask

  // serves for both a first and a repeated start
  task automatic start();
    host_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    host_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask

  task automatic stop();
    host_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    host_low = 1'b0;
    hp();
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      host_low = ~b[i];
      hp();
      scl = 1'b1;
      hp();
      scl = 1'b0;
    end
    host_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    ack = ~sda;
    scl = 1'b0;
  endtask

  task automatic get_byte(output logic [7:0] b, input logic nack);
    host_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hp();
      scl = 1'b1;
      hp();
      b[i] = sda;
      scl = 1'b0;
    end
    host_low = ~nack;
    hp();
    scl = 1'b1;
    hp();
    scl = 1'b0;
  endtask

  task automatic read2(input logic [7:0] a, output logic [15:0] d,
                       output logic ok);
    logic k1, k2, k3;
    start();
    put_byte({arr_pkg::TARGET_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    start();
    put_byte({arr_pkg::TARGET_ADDR, 1'b1}, k3);
    get_byte(d[15:8], 1'b0);
    get_byte(d[7:0], 1'b1);
    stop();
    ok = k1 & k2 & k3;
  endtask

  task automatic write1(input logic [7:0] a, input logic [7:0] v,
                        output logic ok);
    logic k1, k2, k3;
    start();
    put_byte({arr_pkg::TARGET_ADDR, 1'b0}, k1);
    put_byte(a, k2);
    put_byte(v, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask

  task automatic probe(input logic [6:0] t, output logic ack);
    start();
    put_byte({t, 1'b0}, ack);
    stop();
  endtask
endmodule

`default_nettype wire

/* File: verif/arr_result_regs_tb_top.sv */
// self-checking bench of the measurement result register bank
`default_nettype none

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module arr_result_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, reset_n, result_load, reg_reset_cmd, ok;
  logic [7:0]  vo;
  logic [15:0] vb, ib, d;
  wire logic   scl_w, sda_w, sda_out, sda_oe_n;
  int          n_errors, n_checks;

  arr_result_regs uut (
    .clock(clock), .reset_n(reset_n), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .result_load(result_load),
    .output_voltage_result(vo), .battery_voltage_result(vb),
    .battery_current_result(ib), .reg_reset_cmd(reg_reset_cmd));

  arr_host_model host (
    .clock(clock), .dev_oe_n(sda_oe_n), .dev_out(sda_out),
    .scl(scl_w), .sda(sda_w));

  always #25 clock = ~clock;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one-cycle pulse of load and/or register reset with the given results
  task automatic pulse(input logic ld, input logic rr, input logic [7:0] v,
                       input logic [15:0] b, input logic [15:0] i);
    @(posedge clock);
    #5;
    vo            = v;
    vb            = b;
    ib            = i;
    result_load   = ld;
    reg_reset_cmd = rr;
    @(posedge clock);
    #5;
    result_load   = 1'b0;
    reg_reset_cmd = 1'b0;
  endtask

  // reads 0x1d..0x22 in pairs, the second byte of a pair by auto-increment
  task automatic read_all(input logic [7:0] v, input logic [15:0] b,
                          input logic [15:0] i);
    host.read2(arr_pkg::ADDR_VOUT_LOW, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d[15:8], v)
    `CHK(d[7:0], b[15:8])
    host.read2(arr_pkg::ADDR_VBAT_LOW, d, ok);
    `CHK(d[15:8], b[7:0])
    `CHK(d[7:0], i[15:8])
    host.read2(arr_pkg::ADDR_IBAT_LOW, d, ok);
    `CHK(d[15:8], i[7:0])
    `CHK(d[7:0], arr_pkg::UNMAPPED_READ)
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_signs();
    pulse(1'b1, 1'b0, 8'ha5, 16'h8f3c, 16'h7ac1);
    read_all(8'ha5, 16'h8f3c, 16'h7ac1);
    host.read2(arr_pkg::ADDR_VBAT_HIGH, d, ok);
    `CHK(d[15], 1'b1)
    `CHK(d[15:8], 8'h8f)
    pulse(1'b1, 1'b0, 8'h5a, 16'h0123, 16'hf00d);
    host.read2(arr_pkg::ADDR_VBAT_HIGH, d, ok);
    `CHK(d[15], 1'b0)
    host.read2(arr_pkg::ADDR_IBAT_HIGH, d, ok);
    `CHK(d, 16'hf00d)
  endtask

  task automatic t_write_ignored();
    host.write1(arr_pkg::ADDR_VBAT_HIGH, 8'h55, ok);
    `CHK(ok, 1'b1)
    host.write1(arr_pkg::ADDR_IBAT_LOW, 8'haa, ok);
    `CHK(ok, 1'b1)
    read_all(8'h5a, 16'h0123, 16'hf00d);
  endtask

  task automatic t_reg_reset();
    pulse(1'b0, 1'b1, 8'h5a, 16'h0123, 16'hf00d);
    read_all(8'h00, 16'h0000, 16'h0000);
    pulse(1'b1, 1'b0, 8'hff, 16'hffff, 16'h8000);
    pulse(1'b1, 1'b1, 8'h11, 16'h2233, 16'h4455);
    read_all(8'h00, 16'h0000, 16'h0000);
  endtask

  task automatic t_wrong_target();
    host.probe(arr_pkg::TARGET_ADDR ^ 7'h01, ok);
    `CHK(ok, 1'b0)
  endtask

  initial begin
    clock         = 1'b0;
    reset_n       = 1'b0;
    result_load   = 1'b0;
    reg_reset_cmd = 1'b0;
    vo            = 8'h00;
    vb            = 16'h0000;
    ib            = 16'h0000;
    n_errors      = 0;
    n_checks      = 0;
    repeat (20) @(posedge clock);
    #5;
    reset_n = 1'b1;
    repeat (3) @(posedge clock);
    read_all(8'h00, 16'h0000, 16'h0000);
    t_signs();
    t_write_ignored();
    t_reg_reset();
    t_wrong_target();
    summarize();
  end

  // about 20k clocks of traffic expected; cut a hang at three times that
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule

`undef CHK
`default_nettype wire
